// File: design/dfr_pkg.sv
// Shared constants and types of the drive fault reset sequencer
package dfr_pkg;
    // ---------------------------------------------------------------
    // Clock and time figures
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_TIME_S = 1;
    localparam int HOLD_TIME_S = 2;
    localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_TIME_S;
    localparam int HOLD_CYCLES_DEF = CLK_HZ * HOLD_TIME_S;
    localparam logic [6:0] WAIT0_S = 7'd1;
    localparam logic [6:0] WAIT1_S = 7'd5;
    localparam logic [6:0] WAIT2_S = 7'd10;
    localparam logic [6:0] WAIT3_S = 7'd60;
    localparam logic [6:0] SUCCESS_S = 7'd60;
    localparam logic [13:0] LIM_5M_S = 14'd300;
    localparam logic [13:0] LIM_10M_S = 14'd600;
    localparam logic [13:0] LIM_30M_S = 14'd1800;
    localparam logic [13:0] LIM_1H_S = 14'd3600;
    localparam logic [13:0] LIM_2H_S = 14'd7200;
    localparam logic [13:0] LIM_3H_S = 14'd10800;
    // ---------------------------------------------------------------
    // Limit and source codes
    // ---------------------------------------------------------------
    localparam logic [2:0] LIM_5M = 3'd0;
    localparam logic [2:0] LIM_10M = 3'd1;
    localparam logic [2:0] LIM_30M = 3'd2;
    localparam logic [2:0] LIM_1H = 3'd3;
    localparam logic [2:0] LIM_2H = 3'd4;
    localparam logic [2:0] LIM_3H = 3'd5;
    localparam logic [2:0] LIM_UNLIMITED = 3'd6;
    localparam logic [5:0] SRC_NONE = 6'd0;
    localparam logic [5:0] SRC_BASE_LO = 6'd1;
    localparam logic [5:0] SRC_BASE_HI = 6'd6;
    localparam logic [5:0] SRC_EXT_LO = 6'd7;
    localparam logic [5:0] SRC_EXT_HI = 6'd12;
    localparam logic [5:0] SRC_FB_LO = 6'd16;
    localparam logic [5:0] SRC_FB_HI = 6'd30;
    localparam logic [5:0] SRC_ETH_LO = 6'd32;
    localparam logic [5:0] SRC_ETH_HI = 6'd46;
    localparam logic [3:0] PROFILE_ONLY_BITS = 4'd10;
    // ---------------------------------------------------------------
    // Register map and fields
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_CMD = 12'h008;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_EXPERT_BIT = 1;
    localparam int CTRL_LIM_LSB = 4;
    localparam int CTRL_SRC_LSB = 8;
    localparam int CMD_RESTART_BIT = 0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_IDX_LSB = 4;
    localparam int ST_ABORT_BIT = 8;
    localparam int ST_IND_BIT = 9;
    localparam int ST_RELAY_BIT = 10;
    localparam int ST_ELAPSED_LSB = 16;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_AUTO_WAIT = 3'b001,
        ST_AUTO_RUN = 3'b010,
        ST_LOCKED = 3'b011,
        ST_REINIT = 3'b100
    } dfr_state_t;
endpackage

// File: design/dfr_tick_if.sv
// Seconds timebase enable carried from the divider to the sequencer
`timescale 1ns/100ps
interface dfr_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// File: design/dfr_timebase.sv
// Divider that makes a one-cycle enable once per second
`timescale 1ns/100ps
module dfr_timebase
    import dfr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clk,      // System clock
    input wire logic rst,      // Synchronous reset
    dfr_tick_if.src tickOut    // One-second enable
);
    logic [31:0] divCount;
    logic tickReg;
    wire lastCount = (divCount == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            divCount <= ZERO_WORD;
            tickReg <= 1'b0;
        end else begin
            divCount <= lastCount ? ZERO_WORD : divCount + 32'h0000_0001;
            tickReg <= lastCount;
        end
    end

    assign tickOut.tick = tickReg;
endmodule // dfr_timebase

// File: design/dfr_sequencer.sv
// Fault recovery sequencer: automatic, manual and product restart
//
// Behaviour
// - Auto mode clears fault once cause gone
// - Fault indication held off during auto attempts
// - Auto abort on time limit raises fault indication
// - Fault relay stays active while auto enabled
// - Time limit expiry aborts, locks until reset or product restart
// - Waits 1 s, 5 s, 10 s, then 1 min
// - Auto off at reset; retry needs clear cause
// - Limit setting only while auto active
// - Limit choices 5m..3h or unlimited, default 5m
// - Reset source rising edge clears removed errors
// - Panel stop/reset key acts as reset source
// - Source default none; base or extension inputs
// - Command bits 11-15 always; 1-10 in profile
// - Product restart clears fault then reinitialises
// - Product restart needs expert access level
// - Confirm key held 2 s before restart
// - Restart setting drops when reinit completes
// - Reinit request accepted only when locked
// - Product restart clears every error, no mains off
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
module dfr_sequencer
    import dfr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
    input wire logic clk,              // System clock 100 MHz
    input wire logic rst,              // Synchronous reset, high
    input wire logic psel,             // APB select
    input wire logic penable,          // APB enable
    input wire logic pwrite,           // APB direction
    input wire logic [11:0] paddr,     // APB byte address
    input wire logic [31:0] pwdata,    // APB write data
    output logic [31:0] prdata,        // APB read data
    output logic pready,               // APB ready
    output logic pslverr,              // APB error, unmapped address
    input wire logic faultActive,      // Drive is in fault
    input wire logic faultCauseGone,   // Fault cause removed
    input wire logic runPermitted,     // Other run conditions met
    input wire logic extFitted,        // Extension module fitted
    input wire logic ioProfile,        // Drive in I/O control profile
    input wire logic [5:0] baseInPin,  // Base digital inputs 1..6
    input wire logic [5:0] extInPin,   // Extension inputs 11..16
    input wire logic [15:0] fieldbusCmd, // Fieldbus command word
    input wire logic [15:0] ethernetCmd, // Ethernet command word
    input wire logic stopKeyPin,       // Panel stop/reset key
    input wire logic okKeyPin,         // Panel confirm key
    input wire logic initDone,         // Start-up sequence complete
    output logic faultClear,           // Pulse: clear detected errors
    output logic reinitStart,          // Pulse: run start-up sequence
    output logic faultIndication,      // Operating state fault output
    output logic faultRelay            // Drive fault relay, active high
);
    // ---------------------------------------------------------------
    // Lookup functions
    // ---------------------------------------------------------------
    function automatic logic [6:0] waitSec(input logic [1:0] idx);
        case (idx)
            2'd0: waitSec = WAIT0_S;
            2'd1: waitSec = WAIT1_S;
            2'd2: waitSec = WAIT2_S;
            default: waitSec = WAIT3_S;
        endcase
    endfunction

    function automatic logic [13:0] limitSec(input logic [2:0] code);
        case (code)
            LIM_10M: limitSec = LIM_10M_S;
            LIM_30M: limitSec = LIM_30M_S;
            LIM_1H: limitSec = LIM_1H_S;
            LIM_2H: limitSec = LIM_2H_S;
            LIM_3H: limitSec = LIM_3H_S;
            default: limitSec = LIM_5M_S;
        endcase
    endfunction

    function automatic logic srcValid(input logic [5:0] s,
                                      input logic ext, input logic prof);
        if (s <= SRC_BASE_HI) begin
            srcValid = 1'b1;
        end else if (s >= SRC_EXT_LO && s <= SRC_EXT_HI) begin
            srcValid = ext;
        end else if (s >= SRC_FB_LO && s <= SRC_FB_HI) begin
            srcValid = prof || (s - SRC_FB_LO >= 6'(PROFILE_ONLY_BITS));
        end else if (s >= SRC_ETH_LO && s <= SRC_ETH_HI) begin
            srcValid = prof || (s - SRC_ETH_LO >= 6'(PROFILE_ONLY_BITS));
        end else begin
            srcValid = 1'b0;
        end
    endfunction

    // ---------------------------------------------------------------
    // Timebase and pin synchronisers
    // ---------------------------------------------------------------
    dfr_tick_if tickBus ();

    dfr_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) timebase (
        .clk(clk),
        .rst(rst),
        .tickOut(tickBus)
    );

    logic [13:0] pinMeta, pinSync;

    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta <= 14'h0000;
            pinSync <= 14'h0000;
        end else begin
            pinMeta <= {okKeyPin, stopKeyPin, extInPin, baseInPin};
            pinSync <= pinMeta;
        end
    end

    wire [5:0] baseSync = pinSync[5:0];
    wire [5:0] extSync = pinSync[11:6];

    // ---------------------------------------------------------------
    // Registers and state
    // ---------------------------------------------------------------
    dfr_state_t state, next_state;
    logic autoEnable, expertAccess, restartArmed, aborted;
    logic [2:0] limitSel;
    logic [5:0] resetSource;
    logic [1:0] attemptIdx;
    logic [6:0] waitCnt, runCnt;
    logic [13:0] elapsed;
    logic [31:0] holdCnt;
    logic resetSelPrev, stopKeyPrev;
    logic next_faultClear, next_abort;

    wire secTick = tickBus.tick;
    wire apbAccess = psel && penable && pready;
    wire apbWrite = apbAccess && pwrite;
    wire selCtrl = (paddr == OFS_CTRL);
    wire selStatus = (paddr == OFS_STATUS);
    wire selCmd = (paddr == OFS_CMD);
    wire mapped = selCtrl || selStatus || selCmd;
    wire ctrlWrite = apbWrite && selCtrl;
    wire cmdWrite = apbWrite && selCmd;
    wire [5:0] wrSource = pwdata[CTRL_SRC_LSB +: 6];
    wire [2:0] wrLimit = pwdata[CTRL_LIM_LSB +: 3];
    wire wrAuto = pwdata[CTRL_AUTO_BIT];

    wire resetSelOk = srcValid(resetSource, extFitted,
        ioProfile);
    // Source levels indexed by source code, unused codes read low
    wire [63:0] srcVec = {17'h0_0000, ethernetCmd[15:1], 1'b0,
        fieldbusCmd[15:1], 3'h0, extSync, baseSync, 1'b0};
    wire resetSel = resetSelOk && srcVec[resetSource];
    wire stopKey = pinSync[12];
    wire okKey = pinSync[13];
    // Rising edge of the source, or the panel key
    wire manualReq = (resetSel && !resetSelPrev)
        || (stopKey && !stopKeyPrev);
    wire limitHit = (limitSel != LIM_UNLIMITED)
        && (elapsed >= limitSec(limitSel));
    wire waitOver = (waitCnt >= waitSec(attemptIdx));
    wire restartFire = restartArmed && okKey
        && (holdCnt == 32'(HOLD_CYCLES));
    wire autoState = (state == ST_AUTO_WAIT) || (state == ST_AUTO_RUN);
    // A clear just issued is still seen for one cycle on faultActive
    wire newFault = faultActive && !faultClear;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_faultClear = 1'b0;
        next_abort = 1'b0;
        case (state)
            ST_IDLE: begin
                if (newFault) begin
                    next_state = autoEnable ? ST_AUTO_WAIT : ST_LOCKED;
                end
            end
            ST_AUTO_WAIT: begin
                if (!autoEnable) begin
                    next_state = ST_LOCKED;
                end else if (limitHit) begin
                    next_state = ST_LOCKED;
                    next_abort = 1'b1;
                end else if (waitOver && faultCauseGone && runPermitted) begin
                    next_state = ST_AUTO_RUN;
                    next_faultClear = 1'b1;
                end
            end
            ST_AUTO_RUN: begin
                if (newFault) begin
                    next_state = !autoEnable ? ST_LOCKED
                        : (limitHit ? ST_LOCKED : ST_AUTO_WAIT);
                    next_abort = autoEnable && limitHit;
                end else if (!autoEnable || runCnt >= SUCCESS_S) begin
                    next_state = ST_IDLE;
                end
            end
            ST_LOCKED: begin
                if (restartFire) begin
                    next_state = ST_REINIT;
                    next_faultClear = 1'b1;
                end else if (aborted) begin
                    next_state = ST_LOCKED;
                end else if (autoEnable) begin
                    next_state = ST_AUTO_WAIT;
                end else if (manualReq && faultCauseGone) begin
                    next_state = ST_IDLE;
                    next_faultClear = 1'b1;
                end
            end
            ST_REINIT: begin
                if (initDone) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            faultClear <= 1'b0;
            reinitStart <= 1'b0;
            faultIndication <= 1'b0;
            faultRelay <= 1'b1;
            aborted <= 1'b0;
        end else begin
            state <= next_state;
            faultClear <= next_faultClear;
            reinitStart <= restartFire;
            faultIndication <= (next_state == ST_LOCKED);
            faultRelay <= autoEnable
                || (next_state != ST_LOCKED);
            aborted <= (aborted || next_abort) && !restartFire;
        end
    end

    // ---------------------------------------------------------------
    // Attempt, wait and elapsed counters
    // ---------------------------------------------------------------
    wire clearProgress = (state == ST_IDLE) || !autoEnable;
    wire countWait = (state == ST_AUTO_WAIT) && secTick && !(&waitCnt);
    wire countRun = (state == ST_AUTO_RUN) && secTick && !(&runCnt);
    wire countElapsed = autoState && secTick && !(&elapsed);
    wire nextAttempt = (state == ST_AUTO_WAIT) && next_faultClear
        && !(&attemptIdx);

    always_ff @(posedge clk) begin
        if (rst || clearProgress) begin
            attemptIdx <= 2'd0;
            elapsed <= 14'd0;
        end else begin
            attemptIdx <= attemptIdx + {1'b0, nextAttempt};
            elapsed <= elapsed + {13'd0, countElapsed};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            waitCnt <= 7'd0;
            runCnt <= 7'd0;
            resetSelPrev <= 1'b0;
            stopKeyPrev <= 1'b0;
        end else begin
            waitCnt <= (state != ST_AUTO_WAIT) ? 7'd0
                : waitCnt + {6'd0, countWait};
            runCnt <= (state != ST_AUTO_RUN) ? 7'd0
                : runCnt + {6'd0, countRun};
            resetSelPrev <= resetSel;
            stopKeyPrev <= stopKey;
        end
    end

    // ---------------------------------------------------------------
    // Product restart arming and confirm hold
    // ---------------------------------------------------------------
    wire armReq = cmdWrite && pwdata[CMD_RESTART_BIT] && expertAccess
        && (state == ST_LOCKED);
    wire disarm = (state == ST_REINIT && initDone)
        || (!restartArmed ? 1'b0 : (state != ST_LOCKED && state != ST_REINIT));

    always_ff @(posedge clk) begin
        if (rst) begin
            restartArmed <= 1'b0;
            holdCnt <= ZERO_WORD;
        end else begin
            restartArmed <= (restartArmed || armReq) && !disarm;
            if (restartArmed && okKey && state == ST_LOCKED) begin
                holdCnt <= restartFire ? ZERO_WORD
                    : holdCnt + 32'h0000_0001;
            end else begin
                holdCnt <= ZERO_WORD;
            end
        end
    end

    // ---------------------------------------------------------------
    // Configuration register and APB slave
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            autoEnable <= 1'b0;
            expertAccess <= 1'b0;
            limitSel <= LIM_5M;
            resetSource <= SRC_NONE;
        end else if (ctrlWrite) begin
            autoEnable <= wrAuto;
            expertAccess <= pwdata[CTRL_EXPERT_BIT];
            if (wrAuto && wrLimit <= LIM_UNLIMITED) begin
                limitSel <= wrLimit;
            end
            if (srcValid(wrSource, extFitted, ioProfile)) begin
                resetSource <= wrSource;
            end
        end
    end

    logic [31:0] readWord;
    always_comb begin
        readWord = ZERO_WORD;
        if (selCtrl) begin
            readWord[CTRL_AUTO_BIT] = autoEnable;
            readWord[CTRL_EXPERT_BIT] = expertAccess;
            readWord[CTRL_LIM_LSB +: 3] = limitSel;
            readWord[CTRL_SRC_LSB +: 6] = resetSource;
        end else if (selStatus) begin
            readWord[ST_STATE_LSB +: 3] = state;
            readWord[ST_IDX_LSB +: 2] = attemptIdx;
            readWord[ST_ABORT_BIT] = aborted;
            readWord[ST_IND_BIT] = faultIndication;
            readWord[ST_RELAY_BIT] = faultRelay;
            readWord[ST_ELAPSED_LSB +: 14] = elapsed;
        end else if (selCmd) begin
            readWord[CMD_RESTART_BIT] = restartArmed;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= ZERO_WORD;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? ZERO_WORD : readWord;
            end
        end
    end
endmodule // dfr_sequencer

// File: design/dfr_placeholder_none.sv
// Spare design file, holds no logic

// File: test/dfr_sequencer_sva.sv
// Port assertions of the fault reset sequencer
`timescale 1ns/100ps
module dfr_sequencer_sva (
    input wire logic clk,             // Clock
    input wire logic rst,             // Reset
    input wire logic psel,            // Select
    input wire logic penable,         // Enable
    input wire logic [11:0] paddr,    // Address
    input wire logic pready,          // Ready
    input wire logic pslverr,         // Error
    input wire logic faultActive,     // Fault latched
    input wire logic faultClear,      // Clear pulse
    input wire logic reinitStart,     // Start-up pulse
    input wire logic faultIndication, // Fault output
    input wire logic faultRelay       // Relay output
);
    wire mapped = paddr inside {12'h000, 12'h004, 12'h008};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rdy_time; psel && penable && !pready |=> pready; endproperty
    a_rdy_time: assert property (p_rdy_time)
        else $error("ready late");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready stuck");
    property p_err_map; pready |-> (pslverr == !mapped); endproperty
    a_err_map: assert property (p_err_map)
        else $error("bad error flag");
    property p_ind_relay; !faultRelay |-> faultIndication; endproperty
    a_ind_relay: assert property (p_ind_relay)
        else $error("relay off without fault");
    property p_clr_ind; faultClear |-> !faultIndication; endproperty
    a_clr_ind: assert property (p_clr_ind)
        else $error("indication during clear");
    property p_clr_fault; faultClear |-> faultActive; endproperty
    a_clr_fault: assert property (p_clr_fault)
        else $error("clear without fault");
    property p_clr_pulse; faultClear |=> !faultClear; endproperty
    a_clr_pulse: assert property (p_clr_pulse)
        else $error("clear stuck");
    property p_reinit_pair; reinitStart |-> faultClear; endproperty
    a_reinit_pair: assert property (p_reinit_pair)
        else $error("restart without clear");
    c_reinit: cover property (reinitStart);
    c_auto_clr: cover property (faultClear && faultRelay);
    c_err: cover property (pslverr);
endmodule // dfr_sequencer_sva

bind dfr_sequencer dfr_sequencer_sva u_sva (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .faultActive(faultActive), .faultClear(faultClear),
    .reinitStart(reinitStart), .faultIndication(faultIndication),
    .faultRelay(faultRelay));

// File: test/dfr_drive_model.sv
// Behavioural model of the drive fault latch and start-up sequence
`timescale 1ns/100ps
module dfr_drive_model (
    input wire logic clk,         // Clock
    input wire logic rst,         // Reset
    input wire logic trip,        // Raise a fault
    input wire logic faultClear,  // Clear pulse
    input wire logic reinitStart, // Start-up request
    output logic faultActive,     // Latched fault
    output logic runPermitted,    // Run conditions
    output logic initDone         // Start-up complete
);
    logic [3:0] initPipe;
    // Level run command keeps reference and direction during retries
    assign runPermitted = 1'b1;
    assign initDone = initPipe[3];
    always_ff @(posedge clk) begin
        if (rst) begin
            faultActive <= 1'b0;
            initPipe <= 4'h0;
        end else begin
            initPipe <= {initPipe[2:0], reinitStart};
            if (faultClear) begin
                faultActive <= 1'b0;
            end else if (trip) begin
                faultActive <= 1'b1;
            end
        end
    end
endmodule // dfr_drive_model

// File: test/testbench.sv
// Self-checking bench of the drive fault reset sequencer
`timescale 1ns/100ps
module testbench
    import dfr_pkg::*;
;
    localparam int TK = 10;
    localparam int HD = 20;
    typedef struct {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic e;
    } dfr_row_t;
    // d is write data, or the expected read data of a read row
    dfr_row_t rows [14] = '{
        '{1'b0, 12'h000, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h008, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h00C, 32'h0000_0000, 1'b1},
        '{1'b1, 12'h000, 32'h0000_0060, 1'b0},
        '{1'b0, 12'h000, 32'h0000_0000, 1'b0},
        '{1'b1, 12'h000, 32'h0000_0771, 1'b0},
        '{1'b0, 12'h000, 32'h0000_0001, 1'b0},
        '{1'b1, 12'h000, 32'h0000_1011, 1'b0},
        '{1'b0, 12'h000, 32'h0000_0011, 1'b0},
        '{1'b1, 12'h000, 32'h0000_1B01, 1'b0},
        '{1'b0, 12'h000, 32'h0000_1B01, 1'b0},
        '{1'b1, 12'h008, 32'h0000_0001, 1'b0},
        '{1'b1, 12'h004, 32'hFFFF_FFFF, 1'b0},
        '{1'b0, 12'h004, 32'h0000_0400, 1'b0}};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, faultActive, runPermitted, initDone, e;
    logic faultClear, reinitStart, faultIndication, faultRelay;
    logic faultCauseGone = 1'b0, trip = 1'b0, stopKeyPin = 1'b0;
    logic okKeyPin = 1'b0, autoOn = 1'b0, indBad = 1'b0;
    logic [5:0] baseInPin = 6'h00;
    int n_errors = 0, n_checks = 0, c, w, nReinit = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (reinitStart === 1'b1) nReinit++;
        if (autoOn && faultIndication !== 1'b0) indBad = 1'b1;
    end
    dfr_sequencer #(.TICK_CYCLES(TK), .HOLD_CYCLES(HD)) u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .faultActive(faultActive),
        .faultCauseGone(faultCauseGone), .runPermitted(runPermitted),
        .extFitted(1'b0), .ioProfile(1'b0), .baseInPin(baseInPin),
        .extInPin(6'h00), .fieldbusCmd(16'h0000), .ethernetCmd(16'h0000),
        .stopKeyPin(stopKeyPin), .okKeyPin(okKeyPin), .initDone(initDone),
        .faultClear(faultClear), .reinitStart(reinitStart),
        .faultIndication(faultIndication), .faultRelay(faultRelay));
    dfr_drive_model u_model (.clk(clk), .rst(rst), .trip(trip),
        .faultClear(faultClear), .reinitStart(reinitStart),
        .faultActive(faultActive), .runPermitted(runPermitted),
        .initDone(initDone));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_hi(input int s, input int lim, output int n);
        n = 0;
        while ((s == 0 ? faultClear : s == 1 ? reinitStart : faultIndication)
            !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic pulse_trip();
        trip <= 1'b1;
        @(posedge clk);
        trip <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("outs", {faultRelay, faultIndication}, 2'b10);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, r, e);
            chk("err", e, rows[i].e);
            if (!rows[i].w) chk("rd", r, rows[i].d);
        end
        apb(1'b1, OFS_CTRL, 32'h0000_0100, r, e);
        pulse_trip();
        wait_hi(2, 10, c);
        chk("lock", faultRelay, 1'b0);
        baseInPin <= 6'h01;
        wait_hi(0, 8, c);
        chk("noClr", c, 8);
        baseInPin <= 6'h00;
        faultCauseGone <= 1'b1;
        repeat (4) @(posedge clk);
        baseInPin <= 6'h01;
        wait_hi(0, 8, c);
        chk("pinClr", c < 6, 1'b1);
        baseInPin <= 6'h00;
        pulse_trip();
        wait_hi(2, 10, c);
        stopKeyPin <= 1'b1;
        wait_hi(0, 8, c);
        chk("keyClr", c < 6, 1'b1);
        stopKeyPin <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0000_0001, r, e);
        autoOn = 1'b1;
        for (int i = 0; i < 3; i++) begin
            pulse_trip();
            wait_hi(0, 200, c);
            w = i == 0 ? WAIT0_S : i == 1 ? WAIT1_S : WAIT2_S;
            chk("wait", c >= (w - 1) * TK && c <= w * TK + 6, 1'b1);
        end
        autoOn = 1'b0;
        chk("auto", {indBad, faultRelay}, 2'b01);
        faultCauseGone <= 1'b0;
        pulse_trip();
        wait_hi(2, 3400, c);
        chk("abort", {faultIndication, faultRelay}, 2'b11);
        faultCauseGone <= 1'b1;
        stopKeyPin <= 1'b1;
        wait_hi(0, 12, c);
        chk("held", c, 12);
        stopKeyPin <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0000_0002, r, e);
        apb(1'b1, OFS_CMD, 32'h0000_0001, r, e);
        apb(1'b0, OFS_CMD, ZERO_WORD, r, e);
        chk("armed", r, 32'h0000_0001);
        okKeyPin <= 1'b1;
        repeat (HD / 2) @(posedge clk);
        okKeyPin <= 1'b0;
        repeat (5) @(posedge clk);
        chk("short", nReinit, 0);
        okKeyPin <= 1'b1;
        wait_hi(1, 40, c);
        chk("hold", c >= HD && c <= HD + 6, 1'b1);
        okKeyPin <= 1'b0;
        repeat (10) @(posedge clk);
        apb(1'b0, OFS_CMD, ZERO_WORD, r, e);
        chk("done", {r[0], faultIndication}, 2'b00);
        apb(1'b1, OFS_CMD, 32'h0000_0001, r, e);
        apb(1'b0, OFS_CMD, ZERO_WORD, r, e);
        chk("idleArm", r, ZERO_WORD);
        tally_and_finish();
    end
endmodule // testbench
